// >>> hw/ces_pkg.sv
// Package for the cache enable sequencer: register map, field positions,
// reset values, timing counts and the carrier structs.
// Assumes a 100 MHz clock and a 32-bit Avalon-MM register port.
package ces_pkg;

    // ------------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------------
    localparam logic [5:0] ADDR_MAIN_CONTROL  = 6'h00;
    localparam logic [5:0] ADDR_UPKEEP_STATE  = 6'h04;
    localparam logic [5:0] ADDR_WHOLE_UPKEEP  = 6'h08;
    localparam logic [5:0] ADDR_IRQ_PENDING   = 6'h0c;
    localparam logic [5:0] ADDR_IRQ_CLEAR     = 6'h10;
    localparam logic [5:0] ADDR_IRQ_MASK      = 6'h14;
    localparam logic [5:0] ADDR_CONFIG        = 6'h18;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_ENABLE_BIT     = 0;
    localparam int ST_CACHING_BIT      = 0;
    localparam int ST_UPKEEP_BIT       = 1;
    localparam int ST_TRANSITION_BIT   = 2;
    localparam int UPK_FLUSH_BIT       = 0;
    localparam int CFG_SKIP_BIT        = 0;
    localparam int IRQ_SWITCH_ON_BIT   = 0;
    localparam int IRQ_UPKEEP_BIT      = 1;
    localparam int IRQ_WIDTH           = 2;

    // ------------------------------------------------------------------
    // Reset values and constants
    // ------------------------------------------------------------------
    localparam logic [IRQ_WIDTH-1:0] IRQ_RESET   = 2'h0;
    localparam logic [31:0]          READ_ZERO   = 32'h0000_0000;
    localparam logic [31:0]          UNMAPPED_RD = 32'h0000_0000;

    // Whole-cache sweep time, and its cycle count at 100 MHz
    localparam int CLOCK_MHZ        = 100;
    localparam int SWEEP_TIME_NS    = 2560;
    localparam int SWEEP_CYCLES     = (SWEEP_TIME_NS * CLOCK_MHZ + 999) / 1000;
    localparam int SWEEP_CNT_W      = 9;

    // ------------------------------------------------------------------
    // Sequencer states, one-hot
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        CES_IDLE       = 4'b0001,
        CES_EN_UPKEEP  = 4'b0010,
        CES_MAN_UPKEEP = 4'b0100,
        CES_APPLY      = 4'b1000
    } ces_state_e;

    // Decoded register write request
    typedef struct packed {
        logic        ctrl;
        logic        upkeep;
        logic        clear;
        logic        mask;
        logic        config_w;
        logic [31:0] data;
    } ces_wr_s;

    // Sweep engine request and answer
    typedef struct packed {
        logic start;
        logic done;
        logic busy;
    } ces_sweep_s;

endpackage

// >>> hw/ces_sequencer.sv
// Cache enable sequencer: enable command, automatic enable upkeep,
// manual invalidate-all, status and secure interrupt flags.
// Assumes one 100 MHz clock and an Avalon-MM master for the registers.
//
// What this block does (R13 and R14 are what software must do)
// R1: Transition pending flag; active flag changes at end
// R2: Skip clear: run upkeep before applying enable
// R3: Skip set: enable applies immediately
// R4: Disabled cache runs only invalidate-all upkeep
// R5: Pending reads zero idle; write-one clears
// R6: Mask bits enable switch-on and upkeep interrupts
// R7: Writing enable one issues enable command
// R8: Caching active flag set once enable applied
// R9: Switch-on finished pending bit, write-one clears
// R10: Flush trigger starts manual whole-cache invalidation
// R11: Upkeep in progress high while upkeep runs
// R12: Upkeep finished pending bit, write-one clears
// R13: Software invalidates before enable without upkeep
// R14: Software clears pending bits before using interrupts
// R15: Non-secure enable writes are ignored
// R16: Interrupt high when pending and mask overlap
//
// The placing of the registers and the Avalon-MM register port were decided locally.
`timescale 1ns/1ps
module ces_sequencer (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Avalon-MM register slave
    input  wire logic [5:0]  address,
    input  wire logic        read,
    input  wire logic        write,
    input  wire logic [31:0] writedata,
    input  wire logic [3:0]  byteenable,
    input  wire logic        secure,
    output logic [31:0]      readdata,
    output logic             waitrequest,
    // Cache side
    output logic             caching_active,
    output logic             sweep_busy,
    // Interrupt
    output logic             secure_irq
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    typedef struct packed {
        ces_pkg::ces_state_e                fsm;
        logic                               caching_active_flag;
        logic                               enable_req;
        logic                               skip_upkeep_on_switch_on;
        logic [ces_pkg::IRQ_WIDTH-1:0]      secure_irq_pending_reg;
        logic [ces_pkg::IRQ_WIDTH-1:0]      secure_irq_mask_reg;
        logic                               ack;
        logic [31:0]                        rdata;
    } ces_state_s;

    ces_state_s        r;
    ces_state_s        next_r;
    ces_pkg::ces_wr_s  wr;
    ces_pkg::ces_sweep_s sw;
    logic              sw_start;

    // Address decode used by both read and write paths
    function automatic logic hit(input logic [5:0] a, input logic [5:0] reg_addr);
        hit = (a == reg_addr);
    endfunction

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    // Only low byte lane carries fields; writes land on the acking edge
    always_comb begin
        logic go;
        go          = write && r.ack && byteenable[0];
        wr.ctrl     = go && hit(address, ces_pkg::ADDR_MAIN_CONTROL);
        wr.upkeep   = go && hit(address, ces_pkg::ADDR_WHOLE_UPKEEP);
        wr.clear    = go && hit(address, ces_pkg::ADDR_IRQ_CLEAR);
        wr.mask     = go && hit(address, ces_pkg::ADDR_IRQ_MASK);
        wr.config_w = go && hit(address, ces_pkg::ADDR_CONFIG);
        wr.data     = writedata;
    end

    // ------------------------------------------------------------------
    // Invalidation engine
    // ------------------------------------------------------------------
    // Start comes from the sequencer; busy and done from the engine
    assign sw.start = sw_start;

    ces_sweep u_sweep (
        .clock (clock),
        .rst_n (rst_n),
        .start (sw_start),
        .busy  (sw.busy),
        .done  (sw.done)
    );

    // ------------------------------------------------------------------
    // Sequencer and registers
    // ------------------------------------------------------------------
    always_comb begin
        logic [ces_pkg::IRQ_WIDTH-1:0] set_bits;
        logic [ces_pkg::IRQ_WIDTH-1:0] clr_bits;
        logic [31:0]                   rd;
        set_bits = '0;
        clr_bits = '0;
        rd       = ces_pkg::UNMAPPED_RD;
        next_r   = r;
        sw_start = 1'b0;

        // One wait cycle per access, then ack
        next_r.ack = (read || write) && !r.ack;

        // Enable command only from secure writers
        if (wr.ctrl && secure) begin                                // [R15]
            next_r.enable_req = wr.data[ces_pkg::CTRL_ENABLE_BIT];  // [R7]
        end
        if (wr.config_w) begin
            next_r.skip_upkeep_on_switch_on = wr.data[ces_pkg::CFG_SKIP_BIT];
        end
        if (wr.mask) begin                                          // [R6]
            next_r.secure_irq_mask_reg = wr.data[ces_pkg::IRQ_WIDTH-1:0];
        end
        if (wr.clear) begin                                         // [R5]
            clr_bits = wr.data[ces_pkg::IRQ_WIDTH-1:0];
        end

        unique case (r.fsm)
            ces_pkg::CES_IDLE: begin
                if (r.enable_req && !r.caching_active_flag) begin
                    if (r.skip_upkeep_on_switch_on) begin
                        next_r.fsm = ces_pkg::CES_APPLY;           // [R3]
                    end else begin
                        sw_start   = 1'b1;
                        next_r.fsm = ces_pkg::CES_EN_UPKEEP;       // [R2]
                    end
                end else if (!r.enable_req && r.caching_active_flag) begin
                    // Disable path is immediate here; its cleaning is elsewhere
                    next_r.caching_active_flag = 1'b0;
                end else if (wr.upkeep && wr.data[ces_pkg::UPK_FLUSH_BIT]) begin
                    // Invalidate-all is the only upkeep offered here [R4]
                    sw_start   = 1'b1;                              // [R10]
                    next_r.fsm = ces_pkg::CES_MAN_UPKEEP;
                end
            end
            ces_pkg::CES_EN_UPKEEP: begin
                if (sw.done) begin
                    set_bits[ces_pkg::IRQ_UPKEEP_BIT] = 1'b1;       // [R12]
                    next_r.fsm = ces_pkg::CES_APPLY;                // [R2]
                end
            end
            ces_pkg::CES_MAN_UPKEEP: begin
                if (sw.done) begin
                    set_bits[ces_pkg::IRQ_UPKEEP_BIT] = 1'b1;       // [R12]
                    next_r.fsm = ces_pkg::CES_IDLE;
                end
            end
            ces_pkg::CES_APPLY: begin
                // Flag changes only as the transition ends
                next_r.caching_active_flag = 1'b1;                  // [R1] [R8]
                set_bits[ces_pkg::IRQ_SWITCH_ON_BIT] = 1'b1;        // [R9]
                next_r.fsm = ces_pkg::CES_IDLE;
            end
        endcase

        // Set wins over a clear in the same cycle
        next_r.secure_irq_pending_reg =
            (r.secure_irq_pending_reg & ~clr_bits) | set_bits;      // [R5] [R9] [R12]

        // Read mux, registered for the ack edge
        if (hit(address, ces_pkg::ADDR_MAIN_CONTROL)) begin
            rd = ces_pkg::READ_ZERO;
            rd[ces_pkg::CTRL_ENABLE_BIT] = r.enable_req;
        end else if (hit(address, ces_pkg::ADDR_UPKEEP_STATE)) begin
            rd = ces_pkg::READ_ZERO;
            rd[ces_pkg::ST_CACHING_BIT]    = r.caching_active_flag;  // [R8]
            rd[ces_pkg::ST_UPKEEP_BIT]     = sw.busy;               // [R11]
            rd[ces_pkg::ST_TRANSITION_BIT] = (r.fsm != ces_pkg::CES_IDLE
                && r.fsm != ces_pkg::CES_MAN_UPKEEP)
                || (r.enable_req != r.caching_active_flag);         // [R1]
        end else if (hit(address, ces_pkg::ADDR_IRQ_PENDING)) begin
            rd = ces_pkg::READ_ZERO;
            rd[ces_pkg::IRQ_WIDTH-1:0] = r.secure_irq_pending_reg;
        end else if (hit(address, ces_pkg::ADDR_IRQ_MASK)) begin
            rd = ces_pkg::READ_ZERO;
            rd[ces_pkg::IRQ_WIDTH-1:0] = r.secure_irq_mask_reg;
        end else if (hit(address, ces_pkg::ADDR_CONFIG)) begin
            rd = ces_pkg::READ_ZERO;
            rd[ces_pkg::CFG_SKIP_BIT] = r.skip_upkeep_on_switch_on;
        end
        next_r.rdata = (read && !r.ack) ? rd : r.rdata;
    end

    // ------------------------------------------------------------------
    // State register
    // ------------------------------------------------------------------
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r                        <= '0;
            r.fsm                    <= ces_pkg::CES_IDLE;
            r.secure_irq_pending_reg <= ces_pkg::IRQ_RESET;
            r.secure_irq_mask_reg    <= ces_pkg::IRQ_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign waitrequest    = (read || write) && !r.ack;
    assign readdata       = r.rdata;
    assign caching_active = r.caching_active_flag;
    assign sweep_busy     = sw.busy;                                // [R11]
    assign secure_irq     = |(r.secure_irq_pending_reg & r.secure_irq_mask_reg); // [R16]

endmodule // ces_sequencer

// >>> hw/ces_sweep.sv
// Whole-cache invalidation engine: walks every line for a fixed count.
// Assumes start is a one-cycle pulse given only while idle.
`timescale 1ns/1ps
module ces_sweep (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // Control
    input  wire logic start,
    output logic      busy,
    output logic      done
);

    typedef struct packed {
        logic                             busy;
        logic                             done;
        logic [ces_pkg::SWEEP_CNT_W-1:0]  count;
    } ces_sweep_state_s;

    localparam logic [ces_pkg::SWEEP_CNT_W-1:0] LAST =
        ces_pkg::SWEEP_CNT_W'(ces_pkg::SWEEP_CYCLES - 1);

    ces_sweep_state_s r;
    ces_sweep_state_s next_r;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    // Done is a one-cycle pulse in the cycle after the last line, as busy falls
    always_comb begin
        next_r      = r;
        next_r.done = 1'b0;
        if (r.busy) begin
            if (r.count == LAST) begin
                next_r.busy  = 1'b0;
                next_r.done  = 1'b1;
                next_r.count = '0;
            end else begin
                next_r.count = r.count + 1'b1;
            end
        end else if (start) begin
            next_r.busy = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    assign busy = r.busy;
    assign done = r.done;

endmodule // ces_sweep

// >>> test/ces_assertions.sv
// Port checker for the cache enable sequencer.
// Assumes it is bound onto ces_sequencer and sees only its ports.
`timescale 1ns/1ps
module ces_assertions (
    // Clock, reset and register bus
    input wire logic        clock,
    input wire logic        rst_n,
    input wire logic [5:0]  address,
    input wire logic        read,
    input wire logic        write,
    input wire logic [31:0] writedata,
    input wire logic [3:0]  byteenable,
    input wire logic        secure,
    input wire logic [31:0] readdata,
    input wire logic        waitrequest,
    // Status and interrupt
    input wire logic        caching_active,
    input wire logic        sweep_busy,
    input wire logic        secure_irq
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rst_n);
    logic wr1;
    logic idle;
    int   run;
    // Committed write of a one in bit 0, and a quiet cache
    assign wr1  = write && !waitrequest && byteenable[0] && writedata[0];
    assign idle = !sweep_busy && !caching_active;
    // Sweep length, too long for a repetition
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            run <= 0;
        else
            run <= sweep_busy ? run + 1 : 0;
    end
    chk_wait_first: assert property ($rose(read || write) |-> waitrequest)
        else $error("no wait cycle on a new request");
    chk_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
        else $error("more than one wait cycle");
    chk_sweep_len: assert property ($fell(sweep_busy) |-> run == ces_pkg::SWEEP_CYCLES)
        else $error("sweep length wrong");
    chk_sweep_cause: assert property ($rose(sweep_busy) |->
        $past(write) || $past(write, 2) || $past(write, 3))
        else $error("sweep started with no command");
    chk_active_late: assert property ($rose(caching_active) |-> !sweep_busy)
        else $error("enable applied during upkeep");
    chk_flush_go: assert property (wr1 && address == ces_pkg::ADDR_WHOLE_UPKEEP && idle
        |-> ##[1:4] sweep_busy)
        else $error("flush did not start");
    chk_enable_go: assert property (wr1 && secure && address == ces_pkg::ADDR_MAIN_CONTROL
        && idle |-> ##[1:4] (sweep_busy || caching_active))
        else $error("enable command lost");
    chk_nonsec_drop: assert property (wr1 && !secure && address == ces_pkg::ADDR_MAIN_CONTROL
        && idle |=> idle [*4])
        else $error("non-secure enable acted on");
    cover property ($fell(sweep_busy));
    cover property ($rose(caching_active));
    cover property ($rose(secure_irq));
endmodule // ces_assertions

bind ces_sequencer ces_assertions ces_assertions_i (
    .clock(clock), .rst_n(rst_n), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .secure(secure),
    .readdata(readdata), .waitrequest(waitrequest), .caching_active(caching_active),
    .sweep_busy(sweep_busy), .secure_irq(secure_irq));

// >>> test/ces_master_model.sv
// Processor model issuing register accesses on the Avalon-MM port.
// Assumes the bench calls xfer right after a rising edge.
`timescale 1ns/1ps
module ces_master_model (
    // Clock
    input  wire logic        clock,
    // Avalon-MM master side
    output logic [5:0]       address,
    output logic             read,
    output logic             write,
    output logic [31:0]      writedata,
    output logic [3:0]       byteenable,
    output logic             secure,
    input  wire logic [31:0] readdata,
    input  wire logic        waitrequest
);
    logic tmo;
    // Quiet bus at time zero
    initial begin
        {address, read, write, writedata, byteenable, secure} = '0;
        tmo = 1'b0;
    end
    // Held until waitrequest is low; data lines scrambled after release
    task automatic xfer(input logic rd, input logic [5:0] a, input logic [31:0] d,
                        input logic s, output logic [31:0] q);
        int   n;
        logic wq;
        n = 0;
        // Let an edge pass so a release and a new request never share a step
        @(posedge clock);
        address    <= a;
        read       <= rd;
        write      <= !rd;
        writedata  <= d;
        byteenable <= 4'hf;
        secure     <= s;
        // Sampled at the rising edge itself, before the slave updates
        do begin
            @(posedge clock);
            wq = waitrequest;
            q  = readdata;
            n++;
        end while (wq !== 1'b0 && n < 20);
        if (wq !== 1'b0)
            tmo = 1'b1;
        read      <= 1'b0;
        write     <= 1'b0;
        writedata <= ~d;
        address   <= ~a;
    endtask
endmodule // ces_master_model

// >>> test/ces_sequencer_bench.sv
// Self-checking bench for the cache enable sequencer.
// Assumes the checker binds itself and the master model drives the bus.
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin fails++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module ces_sequencer_bench;
    logic        clock, rst_n, read, write, secure;
    logic [5:0]  address;
    logic [31:0] writedata, readdata, q;
    logic [3:0]  byteenable;
    logic        waitrequest, caching_active, sweep_busy, secure_irq;
    logic [2:0]  v;
    int          fails, n_compared;

    ces_sequencer ces_sequencer_i (.clock(clock), .rst_n(rst_n), .address(address),
        .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .secure(secure), .readdata(readdata), .waitrequest(waitrequest),
        .caching_active(caching_active), .sweep_busy(sweep_busy), .secure_irq(secure_irq));
    ces_master_model ces_master_model_i (.clock(clock), .address(address), .read(read),
        .write(write), .writedata(writedata), .byteenable(byteenable), .secure(secure),
        .readdata(readdata), .waitrequest(waitrequest));

    // Verdict and end of run
    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // One bus cycle; a hung slave ends the run
    task automatic go(input logic r, input logic [5:0] a, input logic [31:0] d, input logic s);
        ces_master_model_i.xfer(r, a, d, s, q);
        if (ces_master_model_i.tmo) begin fails++; wrap_up(); end
    endtask
    // Pins read mid-cycle, where they are settled
    task automatic pins();
        @(negedge clock);
        v = {secure_irq, caching_active, sweep_busy};
        @(posedge clock);
    endtask
    // Bounded wait for a status pin; running out counts as a mismatch
    task automatic wait_pin(input logic act, input logic lvl, input int lim);
        int n;
        n = 0;
        do begin pins(); n++; end while (v[act] !== lvl && n < lim);
        if (v[act] !== lvl) begin fails++; wrap_up(); end
    endtask
    task automatic t_reset();
        go(1, ces_pkg::ADDR_IRQ_PENDING, 0, 1); `CHK(q, ces_pkg::READ_ZERO)
        go(1, ces_pkg::ADDR_UPKEEP_STATE, 0, 1); `CHK(q, 32'h0000_0000)
        go(1, 6'h3c, 0, 1); `CHK(q, ces_pkg::UNMAPPED_RD)
    endtask
    // Manual invalidate with a disabled cache, interrupt on, then cleared
    task automatic t_flush();
        go(0, ces_pkg::ADDR_IRQ_MASK, 32'h3, 1);
        go(0, ces_pkg::ADDR_WHOLE_UPKEEP, 32'h1, 1);
        go(1, ces_pkg::ADDR_UPKEEP_STATE, 0, 1); `CHK(q, 32'h0000_0002)
        wait_pin(0, 1'b0, 400);
        go(1, ces_pkg::ADDR_UPKEEP_STATE, 0, 1); `CHK(q, 32'h0000_0000)
        go(1, ces_pkg::ADDR_IRQ_PENDING, 0, 1); `CHK(q, 32'h0000_0002)
        pins(); `CHK(v, 3'b100)
        go(0, ces_pkg::ADDR_IRQ_CLEAR, 32'h2, 1);
        go(1, ces_pkg::ADDR_IRQ_PENDING, 0, 1); `CHK(q, 32'h0000_0000)
        pins(); `CHK(v, 3'b000)
    endtask
    // Skip set: enable lands long before a sweep could end
    task automatic t_skip();
        go(0, ces_pkg::ADDR_CONFIG, 32'h1, 1);
        go(0, ces_pkg::ADDR_MAIN_CONTROL, 32'h1, 1);
        wait_pin(1, 1'b1, 10); `CHK(v, 3'b110)
        go(1, ces_pkg::ADDR_UPKEEP_STATE, 0, 1); `CHK(q, 32'h0000_0001)
        go(1, ces_pkg::ADDR_IRQ_PENDING, 0, 1); `CHK(q, 32'h0000_0001)
        go(0, ces_pkg::ADDR_IRQ_CLEAR, 32'h1, 1);
        go(1, ces_pkg::ADDR_IRQ_PENDING, 0, 1); `CHK(q, 32'h0000_0000)
        go(0, ces_pkg::ADDR_MAIN_CONTROL, 32'h0, 1);
        wait_pin(1, 1'b0, 10);
    endtask
    // Non-secure enable must leave the cache off
    task automatic t_nonsec();
        go(0, ces_pkg::ADDR_MAIN_CONTROL, 32'h1, 0);
        repeat (8) @(posedge clock);
        pins(); `CHK(v, 3'b000)
        go(1, ces_pkg::ADDR_UPKEEP_STATE, 0, 1); `CHK(q, 32'h0000_0000)
    endtask
    // Skip clear: upkeep first, then enable; interrupt masked until late
    task automatic t_auto();
        go(0, ces_pkg::ADDR_CONFIG, 32'h0, 1);
        go(0, ces_pkg::ADDR_IRQ_MASK, 32'h0, 1);
        go(0, ces_pkg::ADDR_MAIN_CONTROL, 32'h1, 1);
        go(1, ces_pkg::ADDR_UPKEEP_STATE, 0, 1); `CHK(q, 32'h0000_0006)
        wait_pin(1, 1'b1, 400);
        go(1, ces_pkg::ADDR_UPKEEP_STATE, 0, 1); `CHK(q, 32'h0000_0001)
        go(1, ces_pkg::ADDR_IRQ_PENDING, 0, 1); `CHK(q, 32'h0000_0003)
        pins(); `CHK(v, 3'b010)
        go(0, ces_pkg::ADDR_IRQ_MASK, 32'h1, 1);
        pins(); `CHK(v, 3'b110)
        go(0, ces_pkg::ADDR_IRQ_CLEAR, 32'h3, 1);
        go(1, ces_pkg::ADDR_IRQ_PENDING, 0, 1); `CHK(q, 32'h0000_0000)
    endtask
    // Clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    // Reset, then each scenario in turn
    initial begin
        rst_n = 1'b0;
        fails = 0;
        n_compared = 0;
        repeat (12) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        t_reset();
        t_flush();
        t_skip();
        t_nonsec();
        t_auto();
        wrap_up();
    end
endmodule // ces_sequencer_bench
